// ### rtl/emtir_cfg.svh
// offsets, field positions, writable masks, reset values and interrupt bit positions of the memory timing and irq block
`ifndef EMTIR_CFG_SVH
`define EMTIR_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define EMTIR_OFS_TIMING    8'h00
`define EMTIR_OFS_SRX       8'h04
`define EMTIR_OFS_RAW       8'h08
`define EMTIR_OFS_MASKED    8'h0C
`define EMTIR_OFS_EN_SET    8'h10
`define EMTIR_OFS_EN_CLR    8'h14
`define EMTIR_OFS_EVENTS    8'h18

// ****************************************************************
// timing and self refresh exit register field positions
// ****************************************************************
`define EMTIR_RFC_HI        31
`define EMTIR_RFC_LO        27
`define EMTIR_RP_HI         26
`define EMTIR_RP_LO         24
`define EMTIR_RCD_HI        22
`define EMTIR_RCD_LO        20
`define EMTIR_WR_HI         18
`define EMTIR_WR_LO         16
`define EMTIR_RAS_HI        15
`define EMTIR_RAS_LO        12
`define EMTIR_RC_HI         11
`define EMTIR_RC_LO         8
`define EMTIR_RRD_HI        6
`define EMTIR_RRD_LO        4
`define EMTIR_XS_HI         4
`define EMTIR_XS_LO         0

// ****************************************************************
// writable masks and reset values
// ****************************************************************
`define EMTIR_TIMING_MASK   32'hFF77_FF70
`define EMTIR_TIMING_RST    32'h4221_5810
`define EMTIR_SRX_MASK      32'h0000_001F
`define EMTIR_SRX_RST       32'h0000_0000
`define EMTIR_IRQ_MASK      3'h7

// ****************************************************************
// interrupt bit positions
// ****************************************************************
`define EMTIR_BIT_TIMEOUT   0
`define EMTIR_BIT_TRAP      1
`define EMTIR_BIT_WRISE     2

`endif

// ### rtl/emtir_pkg.sv
// types of the memory timing and irq block
package emtir_pkg;

	// ****************************************************************
	// sdram spacing fields as the controller sees them
	// ****************************************************************
	typedef struct packed {
		logic [4:0] refresh_cycle_time;        // refresh to refresh, minus one
		logic [2:0] precharge_period;          // precharge to activate/refresh, minus one
		logic [2:0] row_to_column_delay;       // activate to read/write, minus one
		logic [2:0] write_recovery;            // last write to precharge, minus one
		logic [3:0] active_time;               // activate to precharge, minus one
		logic [3:0] row_cycle_time;            // activate to activate, minus one
		logic [2:0] bank_to_bank_activate_gap; // activate to other bank, minus one
		logic [4:0] self_refresh_exit_delay;   // self refresh exit to command, minus one
	} emtir_timing_t;

	// ****************************************************************
	// bus slave state
	// ****************************************************************
	typedef enum logic [1:0] {
		EMTIR_IDLE = 2'b01,
		EMTIR_ACK  = 2'b10
	} emtir_bus_t;

endpackage : emtir_pkg

// ### rtl/emtir_regs.sv
// register bank with sdram spacing fields and wait/trap/timeout interrupt flags
`timescale 1ns/1ps
`include "emtir_cfg.svh"
module emtir_regs #(
	parameter bit HAS_WAIT = 1'b1 // variant with wait, trap and timeout events and flag/enable writes
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// memory side events
	input  wire logic                   memory_wait_input_i,
	input  wire logic                   ext_wait_access_i,
	input  wire logic                   line_trap_event_i,
	input  wire logic [7:0]             extended_wait_limit_i,
	// outputs
	output emtir_pkg::emtir_timing_t    timing_o,
	output logic                        irq_o
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [31:0]          timing_ff;   // sdram spacing register
	logic [31:0]          srx_ff;      // self refresh exit register
	logic [2:0]           raw_ff;      // raw flags
	logic [2:0]           pend_ff;     // masked flags
	logic [2:0]           en_ff;       // interrupt enables
	logic [1:0]           wsync_ff;    // wait input synchroniser
	logic                 wprev_ff;    // previous synced wait
	logic [1:0]           asy_ff;      // access qualifier synchroniser
	logic [1:0]           trap_ff;     // trap synchroniser
	logic [8:0]           wcnt_ff;     // wait active cycles
	logic                 tdone_ff;    // timeout already flagged this wait
	emtir_pkg::emtir_bus_t bus_ff;     // bus slave state
	logic [2:0]           nxt_raw;
	logic [2:0]           nxt_pend;
	logic [2:0]           nxt_en;
	logic [2:0]           ev;          // events this cycle
	logic                 wr_req;      // write accepted this edge
	logic [31:0]          wmask;       // byte enable mask
	logic [31:0]          rdata;
	logic                 timeout_ev;
	logic [2:0]           raw_clr;
	logic [2:0]           en_set;
	logic [2:0]           en_clr;

	// ****************************************************************
	// bus decode
	// ****************************************************************
	// single wait state: ack the cycle after strobe
	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && bus_ff == emtir_pkg::EMTIR_IDLE;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// w1c and set/clear strobes only on byte 0
	always_comb
	begin
		raw_clr = 3'h0;
		en_set  = 3'h0;
		en_clr  = 3'h0;
		if (wr_req && wb_sel_i[0] && HAS_WAIT)
		begin
			case (wb_adr_i)
				`EMTIR_OFS_RAW,
				`EMTIR_OFS_MASKED: raw_clr = wb_dat_i[2:0];
				`EMTIR_OFS_EN_SET: en_set  = wb_dat_i[2:0];
				`EMTIR_OFS_EN_CLR: en_clr  = wb_dat_i[2:0];
				default:           ;
			endcase
		end
	end

	// bus handshake
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bus_ff   <= emtir_pkg::EMTIR_IDLE;
			wb_ack_o <= 1'b0;
		end
		else
		begin
			case (bus_ff)
				emtir_pkg::EMTIR_IDLE:
				begin
					wb_ack_o <= wb_cyc_i && wb_stb_i;
					if (wb_cyc_i && wb_stb_i)
						bus_ff <= emtir_pkg::EMTIR_ACK;
				end
				emtir_pkg::EMTIR_ACK:
				begin
					wb_ack_o <= 1'b0;
					bus_ff   <= emtir_pkg::EMTIR_IDLE;
				end
				default:
				begin
					wb_ack_o <= 1'b0;
					bus_ff   <= emtir_pkg::EMTIR_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// timing registers
	// ****************************************************************
	// reserved positions never store
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timing_ff <= `EMTIR_TIMING_RST;
			srx_ff    <= `EMTIR_SRX_RST;
		end
		else if (wr_req && wb_adr_i == `EMTIR_OFS_TIMING)
			timing_ff <= (timing_ff & ~(wmask & `EMTIR_TIMING_MASK))
				| (wb_dat_i & wmask & `EMTIR_TIMING_MASK);
		else if (wr_req && wb_adr_i == `EMTIR_OFS_SRX)
			srx_ff <= (srx_ff & ~(wmask & `EMTIR_SRX_MASK))
				| (wb_dat_i & wmask & `EMTIR_SRX_MASK);
	end

	// fields handed to the command sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			timing_o <= '0;
		else
		begin
			timing_o.refresh_cycle_time        <= timing_ff[`EMTIR_RFC_HI:`EMTIR_RFC_LO];
			timing_o.precharge_period          <= timing_ff[`EMTIR_RP_HI:`EMTIR_RP_LO];
			timing_o.row_to_column_delay       <= timing_ff[`EMTIR_RCD_HI:`EMTIR_RCD_LO];
			timing_o.write_recovery            <= timing_ff[`EMTIR_WR_HI:`EMTIR_WR_LO];
			timing_o.active_time               <= timing_ff[`EMTIR_RAS_HI:`EMTIR_RAS_LO];
			timing_o.row_cycle_time            <= timing_ff[`EMTIR_RC_HI:`EMTIR_RC_LO];
			timing_o.bank_to_bank_activate_gap <= timing_ff[`EMTIR_RRD_HI:`EMTIR_RRD_LO];
			timing_o.self_refresh_exit_delay   <= srx_ff[`EMTIR_XS_HI:`EMTIR_XS_LO];
		end
	end

	// ****************************************************************
	// event capture
	// ****************************************************************
	// pins pass two flops before use
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wsync_ff <= 2'h0;
			asy_ff   <= 2'h0;
			trap_ff  <= 2'h0;
			wprev_ff <= 1'b0;
		end
		else
		begin
			wsync_ff <= {wsync_ff[0], memory_wait_input_i};
			asy_ff   <= {asy_ff[0], ext_wait_access_i};
			trap_ff  <= {trap_ff[0], line_trap_event_i};
			wprev_ff <= wsync_ff[1];
		end
	end

	// count wait-active cycles in an extended access
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wcnt_ff  <= 9'h000;
			tdone_ff <= 1'b0;
		end
		else if (asy_ff[1] && wsync_ff[1])
		begin
			if (!tdone_ff)
				wcnt_ff <= wcnt_ff + 9'h001;
			if (timeout_ev)
				tdone_ff <= 1'b1;
		end
		else
		begin
			wcnt_ff  <= 9'h000;
			tdone_ff <= 1'b0;
		end
	end

	// one event per wait stretch that outlasts the limit
	assign timeout_ev = asy_ff[1] && wsync_ff[1] && !tdone_ff
		&& wcnt_ff >= {1'b0, extended_wait_limit_i};

	always_comb
	begin
		ev = 3'h0;
		if (HAS_WAIT)
		begin
			ev[`EMTIR_BIT_TIMEOUT] = timeout_ev;
			ev[`EMTIR_BIT_TRAP]    = trap_ff[1];
			ev[`EMTIR_BIT_WRISE]   = wsync_ff[1] && !wprev_ff;
		end
	end

	// ****************************************************************
	// flags and enables
	// ****************************************************************
	// set wins over a same-cycle clear
	always_comb
	begin
		nxt_raw  = (raw_ff & ~raw_clr) | ev;
		nxt_pend = (pend_ff & ~raw_clr) | (ev & en_ff);
		nxt_en   = (en_ff & ~en_clr) | en_set;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			raw_ff  <= 3'h0;
			pend_ff <= 3'h0;
			en_ff   <= 3'h0;
		end
		else
		begin
			raw_ff  <= nxt_raw;
			pend_ff <= nxt_pend;
			en_ff   <= nxt_en;
		end
	end

	// pulse on each new enabled event
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(ev & en_ff);
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	always_comb
	begin
		rdata = 32'h0000_0000;
		case (wb_adr_i)
			`EMTIR_OFS_TIMING: rdata = timing_ff;
			`EMTIR_OFS_SRX:    rdata = srx_ff;
			`EMTIR_OFS_RAW:    rdata = {29'h0, raw_ff};
			`EMTIR_OFS_MASKED: rdata = {29'h0, pend_ff};
			`EMTIR_OFS_EN_SET,
			`EMTIR_OFS_EN_CLR: rdata = {29'h0, en_ff};
			default:           rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && bus_ff == emtir_pkg::EMTIR_IDLE)
			wb_dat_o <= rdata;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(timing_ff & ~`EMTIR_TIMING_MASK) == 32'h0000_0000)
		else $error("timing reserved bit set");
	srx_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(srx_ff & ~`EMTIR_SRX_MASK) == 32'h0000_0000)
		else $error("exit reserved bit set");
	raw_timeout_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timeout_ev |=> raw_ff[0])
		else $error("raw timeout not set");
	timeout_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timeout_ev |=> !timeout_ev)
		else $error("timeout flagged twice");
	wrise_raw_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wsync_ff[1] && !wprev_ff && HAS_WAIT) |=> raw_ff[2])
		else $error("wait rise not flagged");
	trap_raw_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(trap_ff[1] && HAS_WAIT) |=> raw_ff[1])
		else $error("line trap not flagged");
	raw_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(raw_clr[0] && !ev[0]) |=> !raw_ff[0] && !pend_ff[0])
		else $error("w1c did not clear");
	masked_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_req && wb_sel_i[0] && HAS_WAIT && wb_adr_i == `EMTIR_OFS_MASKED
			&& wb_dat_i[1] && !ev[1]) |=> !raw_ff[1] && !pend_ff[1])
		else $error("masked w1c did not clear");
	masked_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pend_ff[0]) |-> $past(en_ff[0]))
		else $error("masked set while disabled");
	irq_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ev[0] && en_ff[0]) |=> irq_o ##1 (!irq_o || $past(|(ev & en_ff))))
		else $error("interrupt pulse wrong");
	timeout_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pend_ff[0]) |-> irq_o)
		else $error("no pulse on masked timeout");
	enable_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_req && wb_sel_i[0] && HAS_WAIT && wb_adr_i == `EMTIR_OFS_EN_SET
			&& wb_dat_i[0]) |=> en_ff[0])
		else $error("enable set failed");
	no_irq_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!en_ff[0] && !pend_ff[0] && !raw_clr[0]) |=> !pend_ff[0])
		else $error("masked timeout while disabled");
	wrise_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pend_ff[2]) |-> $past(en_ff[2]))
		else $error("masked wait rise while disabled");
	trap_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pend_ff[1]) |-> $past(en_ff[1]))
		else $error("masked line trap while disabled");
	enable_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(en_clr[0] && !en_set[0]) |=> !en_ff[0])
		else $error("enable clear failed");
	irq_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == $past(|(ev & en_ff)))
		else $error("interrupt pulse width wrong");
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	// spacing fields reach the sequencer one cycle after the register
	refresh_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.refresh_cycle_time
			== $past(timing_ff[`EMTIR_RFC_HI:`EMTIR_RFC_LO]))
		else $error("refresh field not forwarded");
	precharge_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.precharge_period
			== $past(timing_ff[`EMTIR_RP_HI:`EMTIR_RP_LO]))
		else $error("precharge field not forwarded");
	row_col_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.row_to_column_delay
			== $past(timing_ff[`EMTIR_RCD_HI:`EMTIR_RCD_LO]))
		else $error("row to column field not forwarded");
	recovery_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.write_recovery
			== $past(timing_ff[`EMTIR_WR_HI:`EMTIR_WR_LO]))
		else $error("write recovery field not forwarded");
	active_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.active_time
			== $past(timing_ff[`EMTIR_RAS_HI:`EMTIR_RAS_LO]))
		else $error("active time field not forwarded");
	row_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.row_cycle_time
			== $past(timing_ff[`EMTIR_RC_HI:`EMTIR_RC_LO]))
		else $error("row cycle field not forwarded");
	bank_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.bank_to_bank_activate_gap
			== $past(timing_ff[`EMTIR_RRD_HI:`EMTIR_RRD_LO]))
		else $error("bank gap field not forwarded");
	exit_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> timing_o.self_refresh_exit_delay
			== $past(srx_ff[`EMTIR_XS_HI:`EMTIR_XS_LO]))
		else $error("exit delay field not forwarded");

endmodule : emtir_regs

// ### verification/emtir_mem_model.sv
// memory side model: wait pin, extended-wait access and line trap events
`timescale 1ns/1ps
module emtir_mem_model (
	// clock
	input  wire logic clk_i,
	// memory side events
	output logic      memory_wait_o,
	output logic      ext_access_o,
	output logic      trap_o
);
	// ****************************************************************
	// event generation
	// ****************************************************************
	initial
	begin
		memory_wait_o = 1'b0;
		ext_access_o  = 1'b0;
		trap_o        = 1'b0;
	end

	// one trap event: a single high cycle, then time to settle
	task automatic trap_pulse;
		@(posedge clk_i);
		trap_o <= 1'b1;
		@(posedge clk_i);
		trap_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask : trap_pulse

	// extended-wait access with the device holding wait for n cycles
	task automatic stall(input int n);
		@(posedge clk_i);
		ext_access_o  <= 1'b1;
		memory_wait_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		memory_wait_o <= 1'b0;
		ext_access_o  <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask : stall
endmodule : emtir_mem_model

// ### verification/tb_top.sv
// self-checking bench of the timing and irq register bank
`timescale 1ns/1ps
`include "emtir_cfg.svh"
module tb_top;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic                    clk_i = 1'b0;
	logic                    rst_i = 1'b1;
	logic                    cyc = 1'b0;
	logic                    stb = 1'b0;
	logic                    we = 1'b0;
	logic [7:0]              adr = 8'h00;
	logic [3:0]              sel = 4'h0;
	logic [7:0]              lim = 8'h03; // extended wait limit
	logic [31:0]             dat = 32'h0;
	logic [31:0]             dat_o;
	logic                    ack;
	logic                    mwait;
	logic                    macc;
	logic                    mtrap;
	emtir_pkg::emtir_timing_t timing;
	logic                    irq;
	logic [32:0]             irq_cnt = 33'h0;
	int                      bad_count = 0;
	int                      checks = 0;
	localparam logic [31:0]  PAT = 32'h9A35_C620; // sample timing pattern
	localparam logic [31:0]  RST = `EMTIR_TIMING_RST; // timing reset value

	always #25 clk_i = ~clk_i;

	emtir_regs i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .memory_wait_input_i(mwait),
		.ext_wait_access_i(macc), .line_trap_event_i(mtrap),
		.extended_wait_limit_i(lim), .timing_o(timing), .irq_o(irq)
	);

	emtir_mem_model i_mem (
		.clk_i(clk_i), .memory_wait_o(mwait), .ext_access_o(macc), .trap_o(mtrap)
	);

	// count interrupt cycles; one per enabled event
	always @(posedge clk_i)
		if (irq === 1'b1)
			irq_cnt <= irq_cnt + 33'h1;

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic final_report;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	// classic single wishbone cycle, held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		sel <= 4'hF;
		adr <= a;
		dat <= d;
		// no cycle count assumed; only the watchdog ends a hung wait
		do
		begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk({1'b0, q}, {1'b0, e});
	endtask : rd

	// ****************************************************************
	// watchdog and main sequence
	// ****************************************************************
	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		final_report();
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`EMTIR_OFS_TIMING, 32'h4221_5810);
		rd(`EMTIR_OFS_SRX, 32'h0);
		rd(`EMTIR_OFS_RAW, 32'h0);
		rd(`EMTIR_OFS_MASKED, 32'h0);
		rd(`EMTIR_OFS_EN_SET, 32'h0);
		// all fields at ones, reserved positions written as zero
		wr(`EMTIR_OFS_TIMING, 32'hFF77_FF70);
		rd(`EMTIR_OFS_TIMING, 32'hFF77_FF70);
		wr(`EMTIR_OFS_SRX, 32'h0000_001F);
		rd(`EMTIR_OFS_SRX, 32'h0000_001F);
		wr(`EMTIR_OFS_SRX, 32'h0000_0016);
		wr(`EMTIR_OFS_TIMING, PAT);
		rd(`EMTIR_OFS_TIMING, PAT);
		chk(timing, {PAT[31:27], PAT[26:24], PAT[22:20], PAT[18:16], PAT[15:12],
			PAT[11:8], PAT[6:4], 5'h16});
		rd(8'h40, 32'h0);
		// trap with enables off: raw only, no interrupt
		i_mem.trap_pulse();
		rd(`EMTIR_OFS_RAW, 32'h2);
		rd(`EMTIR_OFS_MASKED, 32'h0);
		chk(irq_cnt, 33'h0);
		wr(`EMTIR_OFS_RAW, 32'h2);
		rd(`EMTIR_OFS_RAW, 32'h0);
		wr(`EMTIR_OFS_EN_SET, 32'h7);
		rd(`EMTIR_OFS_EN_SET, 32'h7);
		rd(`EMTIR_OFS_EN_CLR, 32'h7);
		i_mem.trap_pulse();
		rd(`EMTIR_OFS_MASKED, 32'h2);
		chk(irq_cnt, 33'h1);
		wr(`EMTIR_OFS_MASKED, 32'h2);
		rd(`EMTIR_OFS_RAW, 32'h0);
		// stall exactly as long as the limit: wait rise but no timeout
		i_mem.stall(3);
		rd(`EMTIR_OFS_RAW, 32'h4);
		chk(irq_cnt, 33'h2);
		wr(`EMTIR_OFS_RAW, 32'h4);
		rd(`EMTIR_OFS_MASKED, 32'h0);
		// long stall: timeout with its interrupt enabled
		i_mem.stall(12);
		rd(`EMTIR_OFS_RAW, 32'h5);
		rd(`EMTIR_OFS_MASKED, 32'h5);
		chk(irq_cnt, 33'h4);
		wr(`EMTIR_OFS_MASKED, 32'h7);
		rd(`EMTIR_OFS_RAW, 32'h0);
		// timeout disabled, one cycle past a new limit: raw only, no pulse
		wr(`EMTIR_OFS_EN_CLR, 32'h1);
		rd(`EMTIR_OFS_EN_SET, 32'h6);
		lim <= 8'h05;
		i_mem.stall(6);
		rd(`EMTIR_OFS_RAW, 32'h5);
		rd(`EMTIR_OFS_MASKED, 32'h4);
		chk(irq_cnt, 33'h5);
		wr(`EMTIR_OFS_EN_CLR, 32'h6);
		rd(`EMTIR_OFS_EN_CLR, 32'h0);
		// reset in mid-run brings every register back to its reset value
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`EMTIR_OFS_TIMING, RST);
		chk(timing, {RST[31:27], RST[26:24], RST[22:20], RST[18:16], RST[15:12],
			RST[11:8], RST[6:4], 5'h00});
		rd(`EMTIR_OFS_RAW, 32'h0000_0000);
		rd(`EMTIR_OFS_EN_SET, 32'h0000_0000);
		final_report();
	end
endmodule : tb_top
